// ---- include/swap_pkg.sv ----
// Constants for the single slave swap and restore sequencer.
// Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
package swap_pkg;
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned DONE_HOLD_S    = 5;
    localparam int unsigned DONE_HOLD_CYC  = DONE_HOLD_S * CLK_HZ;
    localparam int unsigned PARAM_COUNT    = 19;
    localparam int unsigned ITEM_COUNT     = PARAM_COUNT + 1;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS        = 8'h00;
    localparam logic [7:0] STATUS_OFS      = 8'h04;
    localparam logic [7:0] OLD_MODEL_OFS   = 8'h08;
    localparam logic [7:0] NEW_MODEL_OFS   = 8'h0C;

    // Control register fields
    localparam int unsigned CTRL_ENABLE_N  = 0;
    localparam int unsigned CTRL_ERR_CLR   = 1;
    localparam int unsigned CTRL_TUNING    = 2;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

    // Status register fields
    localparam int unsigned ST_IN_PROG     = 0;
    localparam int unsigned ST_DONE        = 1;
    localparam int unsigned ST_PA_DONE     = 2;
    localparam int unsigned ST_LINE_BREAK  = 3;
    localparam int unsigned ST_ALARM       = 4;
    localparam int unsigned ST_PA_ERR      = 5;
    localparam int unsigned ST_ABORTED     = 6;

    localparam logic [1:0] RESP_OKAY       = 2'b00;
    localparam logic [1:0] RESP_SLVERR     = 2'b10;

    typedef enum logic [3:0] {
        S_OFF,
        S_POWER_UP,
        S_CHECK_IDS,
        S_DETECT_NEW,
        S_READ_MODEL,
        S_COMPARE,
        S_WRITE_ITEM,
        S_WAIT_ITEM,
        S_DONE_HOLD,
        S_IDLE,
        S_ABORT
    } seq_state_t;
endpackage

// ---- design/swap_axil_regs.sv ----
// AXI4-Lite slave holding the control word and returning status reads.
// Assumes one write and one read outstanding at most.
`timescale 1ns/1ns
module swap_axil_regs
    import swap_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [31:0] status_word,
    input  wire logic [31:0] old_model,
    input  wire logic [31:0] new_model,
    output logic [31:0]      ctrl_q,
    output logic             clear_pulse_q
);
    logic        aw_held_q;
    logic        w_held_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic [31:0] ctrl_d;
    logic [31:0] rdata_d;
    logic [1:0]  rresp_d;
    logic [31:0] byte_mask;

    wire aw_take   = awvalid && awready;
    wire w_take    = wvalid && wready;
    wire do_write  = aw_held_q && w_held_q && !bvalid;
    wire wr_ctrl   = do_write && (awaddr_q == CTRL_OFS);
    wire wr_ro     = (awaddr_q == STATUS_OFS) || (awaddr_q == OLD_MODEL_OFS)
                   || (awaddr_q == NEW_MODEL_OFS);
    wire ar_take   = arvalid && arready;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_mask
            assign byte_mask[gi*8 +: 8] = {8{wstrb_q[gi]}};
        end
    endgenerate

    assign ctrl_d = wr_ctrl ? ((ctrl_q & ~byte_mask) | (wdata_q & byte_mask))
                            : ctrl_q;

    always_comb
    begin
        rresp_d = RESP_OKAY;
        unique case (araddr)
            CTRL_OFS:      rdata_d = ctrl_q;
            STATUS_OFS:    rdata_d = status_word;
            OLD_MODEL_OFS: rdata_d = old_model;
            NEW_MODEL_OFS: rdata_d = new_model;
            default:
            begin
                rdata_d = 32'h0000_0000;
                rresp_d = RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready       <= 1'b1;
            wready        <= 1'b1;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            bvalid        <= 1'b0;
            bresp         <= RESP_OKAY;
            ctrl_q        <= CTRL_RESET;
            clear_pulse_q <= 1'b0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held_q <= 1'b1;
                awaddr_q  <= awaddr;
                awready   <= 1'b0;
            end
            if (w_take)
            begin
                w_held_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
                wready   <= 1'b0;
            end
            ctrl_q        <= ctrl_d;
            // Clear fires on the bit's off-to-on edge
            clear_pulse_q <= wr_ctrl && wstrb_q[0]
                          && wdata_q[CTRL_ERR_CLR] && !ctrl_q[CTRL_ERR_CLR];
            if (do_write)
            begin
                bvalid    <= 1'b1;
                bresp     <= (wr_ctrl || wr_ro) ? RESP_OKAY : RESP_SLVERR;
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rdata_d;
            rresp   <= rresp_d;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule

// ---- design/slave_swap_restore_sequencer.sv ----
// Sequencer that restores a stored backup into one replaced slave module.
// Assumes a line engine that performs the line checks and parameter
// accesses as request / done handshakes on this clock.
`timescale 1ns/1ns

module slave_swap_restore_sequencer
    import swap_pkg::*;
#(
    parameter int unsigned DONE_CYCLES = DONE_HOLD_CYC,
    parameter int unsigned ID_W        = 12,
    parameter int unsigned PARAM_W     = 16
)
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite register bus
    input  wire logic [7:0]         s_awaddr,
    input  wire logic               s_awvalid,
    output logic                    s_awready,
    input  wire logic [31:0]        s_wdata,
    input  wire logic [3:0]         s_wstrb,
    input  wire logic               s_wvalid,
    output logic                    s_wready,
    output logic [1:0]              s_bresp,
    output logic                    s_bvalid,
    input  wire logic               s_bready,
    input  wire logic [7:0]         s_araddr,
    input  wire logic               s_arvalid,
    output logic                    s_arready,
    output logic [31:0]             s_rdata,
    output logic [1:0]              s_rresp,
    output logic                    s_rvalid,
    input  wire logic               s_rready,
    // System conditions
    input  wire logic               module_power,
    input  wire logic               detect_ok,
    input  wire logic               other_slave_error,
    input  wire logic               idless_slave_present,
    input  wire logic               fault_event,
    // Backup captured by automatic address detection
    input  wire logic [ID_W-1:0]    backup_id,
    input  wire logic [31:0]        backup_model,
    input  wire logic [PARAM_W-1:0] backup_param [PARAM_COUNT],
    // Line engine handshake
    output logic                    check_req_q,
    input  wire logic               check_done,
    input  wire logic               old_missing,
    input  wire logic               new_found,
    output logic                    model_req_q,
    input  wire logic               model_done,
    input  wire logic [31:0]        model_value,
    output logic                    write_req_q,
    output logic [4:0]              write_index_q,
    output logic [PARAM_W-1:0]      write_value_q,
    input  wire logic               write_done,
    // Status flags
    output logic                    swap_in_progress_flag,
    output logic                    swap_done_flag,
    output logic                    param_access_done_flag,
    output logic                    line_break_error_flag,
    output logic                    slave_alarm_flag,
    output logic                    param_access_error_flag
);
    initial
    begin
        if (DONE_CYCLES < 1 || ID_W < 1 || ID_W > PARAM_W || PARAM_W > 32)
            $error("slave_swap_restore_sequencer: bad parameters");
    end

    seq_state_t  state_q, state_d;
    logic [31:0] ctrl_q;
    logic        clear_pulse_q;
    logic [31:0] new_model_q;
    logic [31:0] hold_cnt_q;
    logic        aborted_q;
    logic        pwr_s1_q, pwr_q;
    logic        fault_s1_q, fault_q;
    logic [31:0] status_word;
    logic [PARAM_W-1:0] item_value;

    wire swap_enable = !ctrl_q[CTRL_ENABLE_N];
    wire tuning_mode_flag = ctrl_q[CTRL_TUNING];
    wire conditions_ok = detect_ok && swap_enable && !other_slave_error
                      && !idless_slave_present && !tuning_mode_flag;
    wire in_sequence = (state_q != S_OFF) && (state_q != S_IDLE)
                    && (state_q != S_ABORT) && (state_q != S_DONE_HOLD);
    wire abort_now = in_sequence && (fault_q || !conditions_ok);
    wire last_item = (write_index_q == 5'(ITEM_COUNT - 1));
    wire hold_over = (hold_cnt_q == 32'(DONE_CYCLES - 1));
    wire model_match = (new_model_q == backup_model);
    wire [4:0] index_d = (state_q == S_COMPARE) ? 5'h00
                       : (state_q == S_WAIT_ITEM && write_done && !last_item)
                       ? write_index_q + 5'h01 : write_index_q;

    // Item 0 is the module ID, items 1 to 19 are device parameters
    assign item_value = (index_d == 5'h00)
                      ? PARAM_W'(backup_id)
                      : backup_param[index_d - 5'h01];

    assign status_word = {25'h0000000, aborted_q, param_access_error_flag,
                          slave_alarm_flag, line_break_error_flag,
                          param_access_done_flag, swap_done_flag,
                          swap_in_progress_flag};

    swap_axil_regs u_regs
    (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .awaddr        (s_awaddr),
        .awvalid       (s_awvalid),
        .awready       (s_awready),
        .wdata         (s_wdata),
        .wstrb         (s_wstrb),
        .wvalid        (s_wvalid),
        .wready        (s_wready),
        .bresp         (s_bresp),
        .bvalid        (s_bvalid),
        .bready        (s_bready),
        .araddr        (s_araddr),
        .arvalid       (s_arvalid),
        .arready       (s_arready),
        .rdata         (s_rdata),
        .rresp         (s_rresp),
        .rvalid        (s_rvalid),
        .rready        (s_rready),
        .status_word   (status_word),
        .old_model     (backup_model),
        .new_model     (new_model_q),
        .ctrl_q        (ctrl_q),
        .clear_pulse_q (clear_pulse_q)
    );

    // Power and fault come from outside this clock domain
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwr_s1_q   <= 1'b0;
            pwr_q      <= 1'b0;
            fault_s1_q <= 1'b0;
            fault_q    <= 1'b0;
        end
        else
        begin
            pwr_s1_q   <= module_power;
            pwr_q      <= pwr_s1_q;
            fault_s1_q <= fault_event;
            fault_q    <= fault_s1_q;
        end
    end

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            S_OFF:        if (pwr_q) state_d = S_POWER_UP;
            S_POWER_UP:   state_d = conditions_ok ? S_CHECK_IDS : S_IDLE;
            S_CHECK_IDS:  if (check_done)
                              state_d = (old_missing && new_found)
                                      ? S_READ_MODEL : S_IDLE;
            S_DETECT_NEW: state_d = S_READ_MODEL;
            S_READ_MODEL: if (model_done) state_d = S_COMPARE;
            S_COMPARE:    state_d = model_match ? S_WRITE_ITEM : S_IDLE;
            S_WRITE_ITEM: state_d = S_WAIT_ITEM;
            S_WAIT_ITEM:  if (write_done)
                              state_d = last_item ? S_DONE_HOLD : S_WRITE_ITEM;
            S_DONE_HOLD:  if (hold_over) state_d = S_IDLE;
            S_IDLE:       state_d = S_IDLE;
            S_ABORT:      state_d = S_ABORT;
            default:      state_d = S_OFF;
        endcase
        if (abort_now)
            state_d = S_ABORT;
        // Power-off is the only way back to a fresh sequence
        if (!pwr_q)
            state_d = S_OFF;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q       <= S_OFF;
            check_req_q   <= 1'b0;
            model_req_q   <= 1'b0;
            write_req_q   <= 1'b0;
            write_index_q <= 5'h00;
            write_value_q <= '0;
            new_model_q   <= 32'h0000_0000;
            hold_cnt_q    <= 32'h0000_0000;
            aborted_q     <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            check_req_q <= (state_d == S_CHECK_IDS) && !check_done;
            model_req_q <= (state_d == S_READ_MODEL) && !model_done;
            write_req_q <= (state_d == S_WRITE_ITEM);
            if (state_q == S_READ_MODEL && model_done)
                new_model_q <= model_value;
            write_index_q <= index_d;
            if (state_d == S_WRITE_ITEM)
                write_value_q <= item_value;
            hold_cnt_q <= (state_q == S_DONE_HOLD) ? hold_cnt_q + 32'h1
                                                    : 32'h0000_0000;
            if (state_d == S_OFF)
                aborted_q <= 1'b0;
            else if (abort_now)
                aborted_q <= 1'b1;
        end
    end

    wire restore_end = (state_q == S_WAIT_ITEM) && write_done && last_item;
    wire err_clear   = clear_pulse_q || restore_end;

    // Flags; sets take priority over clears, except param_access_done_flag, whose clear in S_CHECK_IDS beats the abort set
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            swap_in_progress_flag   <= 1'b0;
            swap_done_flag          <= 1'b0;
            param_access_done_flag  <= 1'b0;
            line_break_error_flag   <= 1'b0;
            slave_alarm_flag        <= 1'b0;
            param_access_error_flag <= 1'b0;
        end
        else
        begin
            if (state_q == S_OFF && pwr_q)
                param_access_done_flag <= 1'b1;
            else if (state_q == S_CHECK_IDS && check_done && new_found)
                param_access_done_flag <= 1'b0;
            else if (state_q == S_READ_MODEL && model_done)
                param_access_done_flag <= 1'b1;
            else if (state_d == S_WRITE_ITEM && state_q == S_COMPARE)
                param_access_done_flag <= 1'b0;
            else if (restore_end || state_d == S_ABORT)
                param_access_done_flag <= 1'b1;

            if (state_q == S_READ_MODEL && model_done)
                swap_in_progress_flag <= 1'b1;
            else if (restore_end || state_d != state_q
                     && (state_d == S_IDLE || state_d == S_ABORT
                         || state_d == S_OFF))
                swap_in_progress_flag <= 1'b0;

            if (restore_end)
                swap_done_flag <= 1'b1;
            else if (state_q == S_DONE_HOLD && state_d != S_DONE_HOLD)
                swap_done_flag <= 1'b0;

            if (state_q == S_CHECK_IDS && check_done && old_missing)
                line_break_error_flag <= 1'b1;
            else if (err_clear)
                line_break_error_flag <= 1'b0;

            if (fault_q)
                slave_alarm_flag <= 1'b1;
            else if (err_clear)
                slave_alarm_flag <= 1'b0;

            if (abort_now && (state_q == S_READ_MODEL
                              || state_q == S_WAIT_ITEM))
                param_access_error_flag <= 1'b1;
            else if (state_q == S_COMPARE && !model_match)
                param_access_error_flag <= 1'b1;
            else if (err_clear)
                param_access_error_flag <= 1'b0;
        end
    end
endmodule

// ---- sim/swap_assertions.sv ----
// Checks on the swap sequencer's status flags and line requests.
// Bound from the bench top; sees ports only.
`timescale 1ns/1ns
module swap_assertions
    import swap_pkg::*;
#(
    parameter int unsigned DONE_CYCLES = 50,
    parameter int unsigned ID_W        = 12,
    parameter int unsigned PARAM_W     = 16
)
(
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic [ID_W-1:0]    backup_id,
    input wire logic [PARAM_W-1:0] backup_param [PARAM_COUNT],
    input wire logic               model_req_q,
    input wire logic               write_req_q,
    input wire logic [4:0]         write_index_q,
    input wire logic [PARAM_W-1:0] write_value_q,
    input wire logic               swap_in_progress_flag,
    input wire logic               swap_done_flag,
    input wire logic               param_access_done_flag,
    input wire logic               line_break_error_flag,
    input wire logic               slave_alarm_flag,
    input wire logic               param_access_error_flag
);
    logic [31:0] hold_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hold_q <= 32'h0;
        else
            hold_q <= swap_done_flag ? hold_q + 32'h1 : 32'h0;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_finish;
        $fell(swap_in_progress_flag) ##0 swap_done_flag;
    endsequence
    a_flags_exclusive: assert property (
        !(swap_in_progress_flag && swap_done_flag))
        else $error("both flags");
    a_finish_clean: assert property (s_finish |->
        param_access_done_flag && !line_break_error_flag
        && !slave_alarm_flag && !param_access_error_flag)
        else $error("finish flags");
    a_done_source: assert property (
        $rose(swap_done_flag) |-> $fell(swap_in_progress_flag))
        else $error("done source");
    a_done_max: assert property (hold_q <= DONE_CYCLES + 1)
        else $error("done long");
    a_done_min: assert property (
        $fell(swap_done_flag) |-> hold_q >= DONE_CYCLES - 1)
        else $error("done short");
    a_write_busy: assert property (write_req_q |->
        swap_in_progress_flag && !param_access_done_flag)
        else $error("write phase");
    a_write_item: assert property (write_req_q |->
        write_index_q <= 5'd19 && write_value_q == (write_index_q == 0
        ? PARAM_W'(backup_id) : backup_param[write_index_q - 5'd1]))
        else $error("item");
    a_prog_start: assert property ($rose(swap_in_progress_flag) |->
        param_access_done_flag && !write_req_q)
        else $error("progress start");
    a_model_read: assert property (model_req_q |->
        !param_access_done_flag && !swap_in_progress_flag)
        else $error("model read");
endmodule

// ---- sim/swap_line_model.sv ----
// Line engine model for the slave modules.
// Answers each request after lag cycles and records restored items.
`timescale 1ns/1ns
module swap_line_model
    import swap_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        module_power,
    input  wire logic [3:0]  lag,
    input  wire logic [31:0] new_model_cfg,
    input  wire logic        check_req_q,
    input  wire logic        model_req_q,
    input  wire logic        write_req_q,
    input  wire logic [4:0]  write_index_q,
    input  wire logic [15:0] write_value_q,
    output logic             check_done,
    output logic             old_missing,
    output logic             new_found,
    output logic             model_done,
    output logic [31:0]      model_value,
    output logic             write_done
);
    logic [15:0] got [ITEM_COUNT];
    int          n_wr = 0;
    int          wait_n = 0;
    logic        busy = 1'b0, ans_c = 1'b0, ans_m = 1'b0;
    logic        pend;
    initial
    begin
        {check_done, model_done, write_done} = 3'b000;
        model_value = 32'h0;
    end
    // Old unit gone, exactly one unused unit fitted
    assign old_missing = 1'b1;
    assign new_found = 1'b1;
    assign pend = (check_req_q && !ans_c) || (model_req_q && !ans_m) || busy;
    always @(posedge aclk)
    begin
        check_done <= 1'b0;
        model_done <= 1'b0;
        write_done <= 1'b0;
        // Data line not held between answers
        model_value <= ~model_value;
        ans_c <= ans_c && check_req_q;
        ans_m <= ans_m && model_req_q;
        wait_n <= pend ? wait_n + 1 : 0;
        if (pend && wait_n >= lag)
        begin
            wait_n <= 0;
            busy <= 1'b0;
            write_done <= busy;
            check_done <= check_req_q && !ans_c;
            model_done <= model_req_q && !ans_m;
            ans_c <= check_req_q;
            ans_m <= model_req_q;
            if (model_req_q && !ans_m)
                model_value <= new_model_cfg;
        end
        if (!module_power)
            n_wr <= 0;
        else if (write_req_q)
        begin
            got[write_index_q] <= write_value_q;
            n_wr <= n_wr + 1;
            busy <= 1'b1;
        end
    end
endmodule

// ---- sim/slave_swap_restore_sequencer_test.sv ----
// Self-checking bench: register bus, swaps, refusals and abort.
// Line side: swap_line_model.
`timescale 1ns/1ns
module slave_swap_restore_sequencer_test;
    import swap_pkg::*;
    localparam int unsigned DONE_CYCLES = 50;
    logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0;
    logic s_arvalid = 0, s_rready = 0, s_awready, s_wready, s_bvalid;
    logic s_arready, s_rvalid, check_req_q, check_done, old_missing;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0, s_rdata, model_value, d;
    logic [3:0] s_wstrb = 4'hF, lag = 4'h0;
    logic [1:0] s_bresp, s_rresp, r;
    logic module_power = 0, detect_ok = 1, other_slave_error = 0;
    logic idless_slave_present = 0, fault_event = 0, seen_lb = 0;
    logic [11:0] backup_id = 12'h2A5;
    logic [31:0] backup_model = 32'h0000_5A5A, new_model_cfg = 32'h0;
    logic [15:0] backup_param [PARAM_COUNT], write_value_q;
    logic new_found, model_req_q, model_done, write_req_q, write_done;
    logic [4:0] write_index_q;
    logic swap_in_progress_flag, swap_done_flag, param_access_done_flag;
    logic line_break_error_flag, slave_alarm_flag, param_access_error_flag;
    logic [5:0] fl;
    int n_mismatch = 0, total_checks = 0;
    assign fl = {param_access_error_flag, slave_alarm_flag,
        line_break_error_flag, param_access_done_flag, swap_done_flag,
        swap_in_progress_flag};
    slave_swap_restore_sequencer #(.DONE_CYCLES(DONE_CYCLES))
        u_slave_swap_restore_sequencer (.*);
    swap_line_model u_swap_line_model (.*);
    always #5 aclk = ~aclk;
    always @(posedge aclk)
        if (line_break_error_flag === 1'b1)
            seen_lb = 1'b1;
    task complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task hang(input string nm);
        n_mismatch++;
        $display("[FAIL] %s expected answer seen none", nm);
        complete_run();
    endtask
    task wait_fl(input int b, input logic v, input int n);
        for (int i = 0; i < n && fl[b] !== v; i++)
            @(posedge aclk);
        if (fl[b] !== v)
            hang("flag wait");
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (int i = 0; i < 100; i++)
        begin
            @(posedge aclk);
            if (s_awready)
                s_awvalid <= 1'b0;
            if (s_wready)
                s_wvalid <= 1'b0;
            if (s_bvalid)
            begin
                r = s_bresp;
                s_bready <= 1'b0;
                @(posedge aclk);
                return;
            end
        end
        hang("bvalid");
    endtask
    task axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (int i = 0; i < 100; i++)
        begin
            @(posedge aclk);
            if (s_arready)
                s_arvalid <= 1'b0;
            if (s_rvalid)
            begin
                d = s_rdata;
                r = s_rresp;
                s_rready <= 1'b0;
                @(posedge aclk);
                return;
            end
        end
        hang("rvalid");
    endtask
    task power_cycle();
        module_power <= 1'b0;
        repeat (20) @(posedge aclk);
        seen_lb = 1'b0;
        module_power <= 1'b1;
    endtask
    task t_regs();
        axi_rd(STATUS_OFS, d, r);
        chk("status", 32'h0, d);
        axi_rd(OLD_MODEL_OFS, d, r);
        chk("old model", backup_model, d);
        axi_wr(STATUS_OFS, 32'hFFFF_FFFF, r);
        chk("ro bresp", RESP_OKAY, r);
        axi_rd(STATUS_OFS, d, r);
        chk("status kept", 32'h0, d);
        axi_rd(8'h40, d, r);
        chk("bad rresp", RESP_SLVERR, r);
        chk("bad rdata", 32'h0, d);
    endtask
    task t_swap(input logic [3:0] lg);
        lag <= lg;
        new_model_cfg <= backup_model;
        power_cycle();
        wait_fl(2, 1'b1, 50);
        wait_fl(2, 1'b0, 500);
        wait_fl(0, 1'b1, 500);
        wait_fl(1, 1'b1, 2000);
        chk("line break", 1, seen_lb);
        chk("errors", 0, fl[5:3]);
        chk("items", ITEM_COUNT, u_swap_line_model.n_wr);
        for (int i = 0; i < ITEM_COUNT; i++)
            chk("item", i == 0 ? 16'(backup_id) : backup_param[i - 1],
                u_swap_line_model.got[i]);
        repeat (DONE_CYCLES - 5) @(posedge aclk);
        chk("done held", 1, fl[1]);
        wait_fl(1, 1'b0, 20);
    endtask
    task t_mismatch();
        new_model_cfg <= ~backup_model;
        power_cycle();
        wait_fl(5, 1'b1, 500);
        chk("mm writes", 0, u_swap_line_model.n_wr);
        chk("mm flags", 0, fl[1:0]);
        axi_wr(CTRL_OFS, 32'h2, r);
        axi_wr(CTRL_OFS, 32'h0, r);
        chk("cleared", 0, fl[5:4]);
    endtask
    task t_blocked();
        new_model_cfg <= backup_model;
        for (int c = 0; c < 5; c++)
        begin
            detect_ok <= c != 2;
            other_slave_error <= c == 3;
            idless_slave_present <= c == 4;
            axi_wr(CTRL_OFS, c == 0 ? 32'h1 : c == 1 ? 32'h4 : 32'h0, r);
            power_cycle();
            repeat (300) @(posedge aclk);
            chk("blk writes", 0, u_swap_line_model.n_wr);
            chk("blk flags", 0, fl[1:0]);
        end
        idless_slave_present <= 1'b0;
    endtask
    task t_abort();
        lag <= 4'hF;
        power_cycle();
        wait_fl(0, 1'b1, 500);
        repeat (40) @(posedge aclk);
        fault_event <= 1'b1;
        repeat (10) @(posedge aclk);
        chk("fault flags", 0, fl[1:0]);
        fault_event <= 1'b0;
        repeat (100) @(posedge aclk);
        chk("no restart", 0, fl[1:0]);
        axi_rd(STATUS_OFS, d, r);
        chk("aborted", 1, d[ST_ABORTED]);
    endtask
    initial
    begin
        for (int i = 0; i < PARAM_COUNT; i++)
            backup_param[i] = 16'hA000 + 16'(i);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_swap(4'h0);
        t_swap(4'h9);
        t_mismatch();
        t_blocked();
        t_abort();
        complete_run();
    end
endmodule
bind slave_swap_restore_sequencer swap_assertions
    #(.DONE_CYCLES(DONE_CYCLES)) u_swap_assertions (.*);
